// *** hw/bfc_blink_font.sv ***
// blink timing, configuration actions, glyph selection and user font ram
// Summary of operation
// - a configuration write with D4 set resets the blink counters at chip select rise
// - that resync also restarts the multiplex scan sequence
// - a configuration write with D5 set clears both planes of every digit
// - configuration read returns the blink phase level in D7
// - blink phase output is high for first plane, low for second plane
// - lower 7 bits of each digit register select one of 128 glyphs
// - digit msb set shows the inverse glyph pattern
// - codes 0 to 23 use user glyph slots, 24 to 127 use rom
// - slow rate shows each plane one second at a 4 MHz mux clock
// - configuration D3 switches blinking off or on
// - with blinking off only first plane data drives the display
// - with blinking on each pixel follows its two plane bits by phase
// - user glyphs live in 120 ram entries of 7 bits, five per glyph
// - font entries are reached only through register 0x05 via a pointer
// - the font pointer can be written but is never read back
// - a font register read returns the entry at the pointer
// - font write with msb set loads pointer, else stores 7-bit data
// - each font data read or write advances the pointer by one
// - an access at 0xF7 wraps the pointer to 0x80
// - pointer writes of 0xF8 to 0xFF load 0x80 instead
// - the pointer starts at 0x80 after reset
// - unused font entries act as 7-bit scratch storage
`include "bfc_regs.svh"
`default_nettype none
module bfc_blink_font
	import bfc_pkg::*;
#(
	parameter int SLOW_HALF_EDGES = `BFC_SLOW_HALF_EDGES,
	parameter int FAST_HALF_EDGES = `BFC_FAST_HALF_EDGES,
	parameter int SCAN_FRAME_EDGES = `BFC_SCAN_FRAME_EDGES
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic mux_clock,
	input wire logic cmd_valid,
	input wire logic cmd_read,
	input wire logic [6:0] cmd_addr,
	input wire bfc_byte_t cmd_wdata,
	output bfc_byte_t rd_data_q,
	output logic rd_valid_q,
	output logic blink_out_q,
	output bfc_glyph_col_t pix_q,
	output logic [1:0] pix_digit_q,
	output logic [2:0] pix_col_q,
	output logic [9:0] rom_p0_addr_q,
	output logic [9:0] rom_p1_addr_q,
	input wire bfc_glyph_col_t rom_p0_data,
	input wire bfc_glyph_col_t rom_p1_data
);
	localparam int STEP_EDGES = SCAN_FRAME_EDGES / `BFC_SCAN_STEPS;

	if (SLOW_HALF_EDGES < 2 || SLOW_HALF_EDGES >= (1 << 23) ||
		FAST_HALF_EDGES < 2 || FAST_HALF_EDGES >= (1 << 23) ||
		STEP_EDGES < 2 || STEP_EDGES >= (1 << 12)) begin : g_bad_count
		$error("bfc_blink_font: count parameter out of range");
	end

	function automatic logic bfc_is_digit(input logic [6:0] a, input logic [6:0] base);
		bfc_is_digit = (a[6:2] == base[6:2]);
	endfunction : bfc_is_digit

	function automatic bfc_font_idx_t bfc_ptr_next(input bfc_font_idx_t p);
		if (p == 7'(`BFC_PTR_LAST - `BFC_PTR_BASE)) begin
			bfc_ptr_next = 7'h00;
		end else begin
			bfc_ptr_next = p + 7'h01;
		end
	endfunction : bfc_ptr_next

	logic mclk_s1_q, mclk_s2_q, mclk_s3_q, mclk_rise;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mclk_s1_q <= 1'b0;
			mclk_s2_q <= 1'b0;
			mclk_s3_q <= 1'b0;
		end else begin
			mclk_s1_q <= mux_clock;
			mclk_s2_q <= mclk_s1_q;
			mclk_s3_q <= mclk_s2_q;
		end
	end

	assign mclk_rise = mclk_s2_q & ~mclk_s3_q;

	bfc_byte_t cfg_q, cfg_d;
	bfc_byte_t p0_q [4], p0_d [4];
	bfc_byte_t p1_q [4], p1_d [4];
	bfc_glyph_col_t ram_q [`BFC_FONT_ENTRIES], ram_d [`BFC_FONT_ENTRIES];
	bfc_font_idx_t fptr_q, fptr_d;
	logic [22:0] blink_cnt_q, blink_cnt_d;
	logic blink_d, rd_valid_d;
	logic [11:0] scan_cnt_q, scan_cnt_d;
	logic [1:0] scan_digit_q, scan_digit_d;
	logic [2:0] scan_col_q, scan_col_d;
	bfc_byte_t rd_data_d;
	bfc_glyph_col_t upix0_q, upix0_d, upix1_q, upix1_d, pix_d, font_cur;
	logic user0_q, user0_d, user1_q, user1_d;
	logic inv0_q, inv0_d, inv1_q, inv1_d;
	logic [1:0] a_digit_q, a_digit_d, pix_digit_d;
	logic [2:0] a_col_q, a_col_d, pix_col_d;
	logic [9:0] rom_p0_addr_d, rom_p1_addr_d;

	assign font_cur = ram_q[fptr_q];

	always_comb begin
		logic [22:0] half_last;
		bfc_byte_t code0;
		bfc_byte_t code1;
		bfc_font_idx_t uidx0;
		bfc_font_idx_t uidx1;
		bfc_glyph_col_t raw0;
		bfc_glyph_col_t raw1;
		half_last = cfg_q[`BFC_CFG_B] ? 23'(FAST_HALF_EDGES - 1) : 23'(SLOW_HALF_EDGES - 1);
		code0 = p0_q[scan_digit_q];
		code1 = p1_q[scan_digit_q];
		uidx0 = 7'(code0[4:0]) * 7'(`BFC_GLYPH_COLS) + 7'(scan_col_q);
		uidx1 = 7'(code1[4:0]) * 7'(`BFC_GLYPH_COLS) + 7'(scan_col_q);
		raw0 = 7'h00;
		raw1 = 7'h00;
		cfg_d = cfg_q;
		p0_d = p0_q;
		p1_d = p1_q;
		ram_d = ram_q;
		fptr_d = fptr_q;
		blink_cnt_d = blink_cnt_q;
		blink_d = blink_out_q;
		scan_cnt_d = scan_cnt_q;
		scan_digit_d = scan_digit_q;
		scan_col_d = scan_col_q;
		rd_data_d = rd_data_q;
		rd_valid_d = 1'b0;
		if (mclk_rise) begin
			if (blink_cnt_q >= half_last) begin
				blink_cnt_d = 23'h000000;
				blink_d = ~blink_out_q;
			end else begin
				blink_cnt_d = blink_cnt_q + 23'h000001;
			end
			if (scan_cnt_q >= 12'(STEP_EDGES - 1)) begin
				scan_cnt_d = 12'h000;
				if (scan_col_q == 3'(`BFC_GLYPH_COLS - 1)) begin
					scan_col_d = 3'h0;
					scan_digit_d = scan_digit_q + 2'h1;
				end else begin
					scan_col_d = scan_col_q + 3'h1;
				end
			end else begin
				scan_cnt_d = scan_cnt_q + 12'h001;
			end
		end
		if (cmd_valid && cmd_read) begin
			rd_valid_d = 1'b1;
			rd_data_d = 8'h00;
			if (cmd_addr == `BFC_ADDR_CONFIG) begin
				rd_data_d = cfg_q;
				rd_data_d[`BFC_CFG_P] = blink_out_q;
			end else if (cmd_addr == `BFC_ADDR_FONT) begin
				rd_data_d = {1'b0, font_cur};
				fptr_d = bfc_ptr_next(fptr_q);
			end else if (bfc_is_digit(cmd_addr, `BFC_ADDR_P0_BASE)) begin
				rd_data_d = p0_q[cmd_addr[1:0]];
			end else if (bfc_is_digit(cmd_addr, `BFC_ADDR_P1_BASE)) begin
				rd_data_d = p1_q[cmd_addr[1:0]];
			end
		end else if (cmd_valid) begin
			if (cmd_addr == `BFC_ADDR_CONFIG) begin
				cfg_d = cmd_wdata;
				cfg_d[`BFC_CFG_P] = 1'b0;
				cfg_d[6] = 1'b0;
				cfg_d[1] = 1'b0;
				if (cmd_wdata[`BFC_CFG_T]) begin
					blink_cnt_d = 23'h000000;
					blink_d = 1'b1;
					scan_cnt_d = 12'h000;
					scan_col_d = 3'h0;
					scan_digit_d = 2'h0;
				end
				if (cmd_wdata[`BFC_CFG_R]) begin
					for (int i = 0; i < 4; i++) begin
						p0_d[i] = `BFC_DIGIT_CLEAR;
						p1_d[i] = `BFC_DIGIT_CLEAR;
					end
				end
			end else if (cmd_addr == `BFC_ADDR_FONT) begin
				if (cmd_wdata[7]) begin
					if (cmd_wdata > `BFC_PTR_LAST) begin
						fptr_d = 7'h00;
					end else begin
						fptr_d = 7'(cmd_wdata - `BFC_PTR_BASE);
					end
				end else begin
					ram_d[fptr_q] = cmd_wdata[6:0];
					fptr_d = bfc_ptr_next(fptr_q);
				end
			end else if (bfc_is_digit(cmd_addr, `BFC_ADDR_P0_BASE)) begin
				p0_d[cmd_addr[1:0]] = cmd_wdata;
			end else if (bfc_is_digit(cmd_addr, `BFC_ADDR_P1_BASE)) begin
				p1_d[cmd_addr[1:0]] = cmd_wdata;
			end else if (bfc_is_digit(cmd_addr, `BFC_ADDR_BOTH_BASE)) begin
				p0_d[cmd_addr[1:0]] = cmd_wdata;
				p1_d[cmd_addr[1:0]] = cmd_wdata;
			end
		end
		a_digit_d = scan_digit_q;
		a_col_d = scan_col_q;
		rom_p0_addr_d = {code0[6:0], scan_col_q};
		rom_p1_addr_d = {code1[6:0], scan_col_q};
		user0_d = (code0[6:0] < 7'(`BFC_USER_GLYPHS));
		user1_d = (code1[6:0] < 7'(`BFC_USER_GLYPHS));
		upix0_d = user0_d ? ram_q[uidx0] : 7'h00;
		upix1_d = user1_d ? ram_q[uidx1] : 7'h00;
		inv0_d = code0[7];
		inv1_d = code1[7];
		raw0 = (user0_q ? upix0_q : rom_p0_data) ^ {7{inv0_q}};
		raw1 = (user1_q ? upix1_q : rom_p1_data) ^ {7{inv1_q}};
		if (cfg_q[`BFC_CFG_E]) begin
			pix_d = blink_out_q ? raw0 : raw1;
		end else begin
			pix_d = raw0;
		end
		pix_digit_d = a_digit_q;
		pix_col_d = a_col_q;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= `BFC_CFG_RESET;
			for (int i = 0; i < 4; i++) begin
				p0_q[i] <= `BFC_DIGIT_RESET;
				p1_q[i] <= `BFC_DIGIT_RESET;
			end
			for (int j = 0; j < `BFC_FONT_ENTRIES; j++) begin
				ram_q[j] <= 7'h00;
			end
			fptr_q <= 7'h00;
			blink_cnt_q <= 23'h000000;
			blink_out_q <= 1'b1;
			scan_cnt_q <= 12'h000;
			scan_digit_q <= 2'h0;
			scan_col_q <= 3'h0;
			rd_data_q <= 8'h00;
			rd_valid_q <= 1'b0;
			upix0_q <= 7'h00;
			upix1_q <= 7'h00;
			user0_q <= 1'b0;
			user1_q <= 1'b0;
			inv0_q <= 1'b0;
			inv1_q <= 1'b0;
			a_digit_q <= 2'h0;
			a_col_q <= 3'h0;
			rom_p0_addr_q <= 10'h000;
			rom_p1_addr_q <= 10'h000;
			pix_q <= 7'h00;
			pix_digit_q <= 2'h0;
			pix_col_q <= 3'h0;
		end else begin
			cfg_q <= cfg_d;
			p0_q <= p0_d;
			p1_q <= p1_d;
			ram_q <= ram_d;
			fptr_q <= fptr_d;
			blink_cnt_q <= blink_cnt_d;
			blink_out_q <= blink_d;
			scan_cnt_q <= scan_cnt_d;
			scan_digit_q <= scan_digit_d;
			scan_col_q <= scan_col_d;
			rd_data_q <= rd_data_d;
			rd_valid_q <= rd_valid_d;
			upix0_q <= upix0_d;
			upix1_q <= upix1_d;
			user0_q <= user0_d;
			user1_q <= user1_d;
			inv0_q <= inv0_d;
			inv1_q <= inv1_d;
			a_digit_q <= a_digit_d;
			a_col_q <= a_col_d;
			rom_p0_addr_q <= rom_p0_addr_d;
			rom_p1_addr_q <= rom_p1_addr_d;
			pix_q <= pix_d;
			pix_digit_q <= pix_digit_d;
			pix_col_q <= pix_col_d;
		end
	end

	logic cfg_wr, font_wr, font_rd;
	assign cfg_wr = cmd_valid && !cmd_read && cmd_addr == `BFC_ADDR_CONFIG;
	assign font_wr = cmd_valid && !cmd_read && cmd_addr == `BFC_ADDR_FONT;
	assign font_rd = cmd_valid && cmd_read && cmd_addr == `BFC_ADDR_FONT;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_ptr_range: assert property (fptr_q < 7'(`BFC_FONT_ENTRIES))
		else $error("font pointer out of range");
	a_resync_blink: assert property (cfg_wr && cmd_wdata[`BFC_CFG_T]
		|=> blink_out_q && blink_cnt_q == 23'h000000)
		else $error("resync did not reset blink timing");
	a_resync_scan: assert property (cfg_wr && cmd_wdata[`BFC_CFG_T]
		|=> scan_cnt_q == 12'h000 && scan_col_q == 3'h0 && scan_digit_q == 2'h0)
		else $error("resync did not restart scan");
	a_wipe_digits: assert property (cfg_wr && cmd_wdata[`BFC_CFG_R]
		|=> p0_q[0] == 8'h00 && p1_q[0] == 8'h00 && p0_q[3] == 8'h00 && p1_q[3] == 8'h00)
		else $error("digit wipe failed");
	a_keep_digits: assert property (cfg_wr && !cmd_wdata[`BFC_CFG_R]
		|=> p0_q[2] == $past(p0_q[2]) && p1_q[2] == $past(p1_q[2]))
		else $error("digit data lost without wipe");
	a_phase_read: assert property (cmd_valid && cmd_read && cmd_addr == `BFC_ADDR_CONFIG
		|=> rd_valid_q && rd_data_q[7] == $past(blink_out_q))
		else $error("phase readback wrong");
	a_phase_toggle: assert property (!cfg_wr && $changed(blink_out_q)
		|-> blink_cnt_q == 23'h000000)
		else $error("blink phase changed mid period");
	a_ptr_clamp: assert property (font_wr && cmd_wdata > `BFC_PTR_LAST
		|=> fptr_q == 7'h00)
		else $error("out of range pointer not clamped");
	a_ptr_wrap: assert property ((font_rd || (font_wr && !cmd_wdata[7])) && fptr_q == 7'h77
		|=> fptr_q == 7'h00)
		else $error("pointer did not wrap");
	a_ptr_step: assert property ((font_rd || (font_wr && !cmd_wdata[7])) && fptr_q < 7'h77
		|=> fptr_q == $past(fptr_q) + 7'h01)
		else $error("pointer did not advance");
	a_font_read: assert property (font_rd
		|=> rd_data_q[7] == 1'b0 && rd_data_q[6:0] == $past(font_cur))
		else $error("font read data wrong");
	a_font_store: assert property (font_wr && !cmd_wdata[7]
		|=> ram_q[$past(fptr_q)] == $past(cmd_wdata[6:0]))
		else $error("font data not stored at pointer");

	c_resync: cover property (cfg_wr && cmd_wdata[`BFC_CFG_T]);
	c_wipe: cover property (cfg_wr && cmd_wdata[`BFC_CFG_R]);
	c_wrap: cover property (font_wr && !cmd_wdata[7] && fptr_q == 7'h77);
	c_phase_flip: cover property ($fell(blink_out_q));
endmodule : bfc_blink_font
`default_nettype wire

// *** hw/bfc_regs.svh ***
// register offsets, field positions, reset values and timing counts of the blink/font block
`ifndef BFC_REGS_SVH
`define BFC_REGS_SVH
`define BFC_ADDR_CONFIG 7'h04
`define BFC_ADDR_FONT 7'h05
`define BFC_ADDR_P0_BASE 7'h20
`define BFC_ADDR_P1_BASE 7'h40
`define BFC_ADDR_BOTH_BASE 7'h60
`define BFC_CFG_S 0
`define BFC_CFG_B 2
`define BFC_CFG_E 3
`define BFC_CFG_T 4
`define BFC_CFG_R 5
`define BFC_CFG_P 7
`define BFC_CFG_RESET 8'h00
`define BFC_DIGIT_RESET 8'h20
`define BFC_DIGIT_CLEAR 8'h00
`define BFC_PTR_BASE 8'h80
`define BFC_PTR_LAST 8'hF7
`define BFC_FONT_ENTRIES 120
`define BFC_USER_GLYPHS 24
`define BFC_GLYPH_COLS 5
`define BFC_MUX_REF_HZ 4000000
`define BFC_SLOW_HALF_S 1
`define BFC_SLOW_HALF_EDGES (`BFC_SLOW_HALF_S * `BFC_MUX_REF_HZ)
`define BFC_FAST_HALF_EDGES (`BFC_SLOW_HALF_EDGES / 2)
`define BFC_SCAN_FRAME_EDGES 5600
`define BFC_SCAN_STEPS 20
`endif

// *** hw/bfc_pkg.sv ***
// types shared by the blink/font block
`default_nettype none
package bfc_pkg;
	typedef logic [7:0] bfc_byte_t;
	typedef logic [6:0] bfc_glyph_col_t;
	typedef logic [6:0] bfc_font_idx_t;
endpackage : bfc_pkg
`default_nettype wire

// *** tb/bfc_host_model.sv ***
// host model issuing register frames to the blink/font block
`default_nettype none
module bfc_host_model
	import bfc_pkg::*;
(
	input wire logic clk,
	input wire bfc_byte_t rd_data_q,
	input wire logic rd_valid_q,
	output logic cmd_valid,
	output logic cmd_read,
	output logic [6:0] cmd_addr,
	output bfc_byte_t cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_addr = 7'h7F;
		cmd_wdata = 8'hFF;
	end
	// one frame taken at one edge; released address and data lines show the inverse, not stale values
	task automatic frame(input logic rd, input logic [6:0] a, input bfc_byte_t d);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_read <= rd;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_addr <= ~a;
		cmd_wdata <= ~d;
	endtask : frame
	task automatic wr(input logic [6:0] a, input bfc_byte_t d);
		frame(1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [6:0] a, output bfc_byte_t d, output logic ok);
		int n;
		frame(1'b1, a, 8'h00);
		ok = 1'b0;
		d = 8'h00;
		for (n = 0; n < 4 && !ok; n++) begin
			#1;
			if (rd_valid_q === 1'b1) begin
				ok = 1'b1;
				d = rd_data_q;
			end else begin
				@(posedge clk);
			end
		end
	endtask : rd
endmodule : bfc_host_model
`default_nettype wire

// *** tb/bfc_blink_font_tb_top.sv ***
// testbench top for the blink/font block
`default_nettype none
module bfc_blink_font_tb_top
	import bfc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mux_clock = 1'b0;
	logic cmd_valid, cmd_read, rd_valid_q, blink_out_q;
	logic [6:0] cmd_addr;
	bfc_byte_t cmd_wdata, rd_data_q;
	bfc_glyph_col_t pix_q, rom_p0_data, rom_p1_data;
	logic [1:0] pix_digit_q;
	logic [2:0] pix_col_q;
	logic [9:0] rom_p0_addr_q, rom_p1_addr_q;
	int err_total = 0;
	int checks_done = 0;
	int i;
	always #12.5 clk = ~clk;
	always #100 mux_clock = ~mux_clock;
	// glyph rom stand-in: every column of a code shows the code itself
	assign rom_p0_data = rom_p0_addr_q[9:3];
	assign rom_p1_data = rom_p1_addr_q[9:3];
	bfc_blink_font #(.SLOW_HALF_EDGES(20), .FAST_HALF_EDGES(10), .SCAN_FRAME_EDGES(100)) i_dut (
		.clk(clk), .sys_rst(sys_rst), .mux_clock(mux_clock), .cmd_valid(cmd_valid),
		.cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .blink_out_q(blink_out_q),
		.pix_q(pix_q), .pix_digit_q(pix_digit_q), .pix_col_q(pix_col_q),
		.rom_p0_addr_q(rom_p0_addr_q), .rom_p1_addr_q(rom_p1_addr_q),
		.rom_p0_data(rom_p0_data), .rom_p1_data(rom_p1_data));
	bfc_host_model i_host (.clk(clk), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
		.cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata));
	task automatic summarize();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	task automatic chk(input bfc_byte_t got, input bfc_byte_t exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic rchk(input logic [6:0] a, input bfc_byte_t exp);
		bfc_byte_t d;
		logic ok;
		i_host.rd(a, d, ok);
		if (ok !== 1'b1) begin
			err_total++;
			summarize();
		end else begin
			chk(d, exp);
		end
	endtask : rchk
	task automatic at_pos(input logic [1:0] dg, input logic [2:0] c);
		int n;
		// leave a column already showing so the check lands early in a fresh one
		for (n = 0; n < 2000 && pix_digit_q === dg && pix_col_q === c; n++) begin
			@(posedge clk);
			#1;
		end
		for (n = 0; n < 2000 && !(pix_digit_q === dg && pix_col_q === c); n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 2000) begin
			err_total++;
			summarize();
		end else begin
			repeat (3) @(posedge clk);
			#1;
		end
	endtask : at_pos
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		rchk(7'h04, 8'h80);
		rchk(7'h43, 8'h20);
		rchk(7'h60, 8'h00);
		i_host.wr(7'h20, 8'h41);
		i_host.wr(7'h04, 8'h00);
		rchk(7'h20, 8'h41);
		i_host.wr(7'h04, 8'h20);
		rchk(7'h20, 8'h00);
		rchk(7'h40, 8'h00);
		i_host.wr(7'h05, 8'h33);
		rchk(7'h05, 8'h00);
		i_host.wr(7'h05, 8'h80);
		rchk(7'h05, 8'h33);
		i_host.wr(7'h05, 8'h80);
		i_host.wr(7'h05, 8'h11);
		i_host.wr(7'h05, 8'hF6);
		i_host.wr(7'h05, 8'h7F);
		i_host.wr(7'h05, 8'h55);
		rchk(7'h05, 8'h11);
		i_host.wr(7'h05, 8'hFA);
		rchk(7'h05, 8'h11);
		i_host.wr(7'h05, 8'hF6);
		rchk(7'h05, 8'h7F);
		rchk(7'h05, 8'h55);
		i_host.wr(7'h05, 8'h85);
		i_host.wr(7'h05, 8'h2A);
		i_host.wr(7'h05, 8'h15);
		for (i = 0; i < 4; i++) begin
			i_host.wr(7'h20 + 7'(i), 8'h30);
			i_host.wr(7'h40 + 7'(i), 8'hB1);
		end
		i_host.wr(7'h04, 8'h18);
		settle();
		chk({3'h0, pix_digit_q, pix_col_q}, 8'h00);
		chk({1'b0, pix_q}, 8'h30);
		chk({7'h00, blink_out_q}, 8'h01);
		repeat (15) @(posedge mux_clock);
		chk({7'h00, blink_out_q}, 8'h01);
		repeat (10) @(posedge mux_clock);
		chk({7'h00, blink_out_q}, 8'h00);
		chk({1'b0, pix_q}, 8'h4E);
		rchk(7'h04, 8'h18);
		i_host.wr(7'h04, 8'h08);
		settle();
		chk({7'h00, blink_out_q}, 8'h00);
		rchk(7'h04, 8'h08);
		i_host.wr(7'h04, 8'h1C);
		repeat (5) @(posedge mux_clock);
		chk({7'h00, blink_out_q}, 8'h01);
		repeat (10) @(posedge mux_clock);
		chk({7'h00, blink_out_q}, 8'h00);
		i_host.wr(7'h04, 8'h04);
		settle();
		chk({1'b0, pix_q}, 8'h30);
		i_host.wr(7'h60, 8'h01);
		i_host.wr(7'h61, 8'h18);
		at_pos(2'd0, 3'd0);
		chk({1'b0, pix_q}, 8'h2A);
		at_pos(2'd0, 3'd1);
		chk({1'b0, pix_q}, 8'h15);
		at_pos(2'd1, 3'd0);
		chk({1'b0, pix_q}, 8'h18);
		summarize();
	end
endmodule : bfc_blink_font_tb_top
`default_nettype wire
